// file: logic/nptc_pkg.sv
package nptc_pkg;
	// Reference clock period of the sequencer, in ns
	localparam int CLK_NS = 20;
	// Device timing figures, in ns
	localparam int T_BULK_NS = 8_400_000;
	localparam int T_ROW_NS = 2_800_000;
	localparam int T_PINT_PM_NS = 2_800_000;
	localparam int T_PINT_CFG_NS = 5_600_000;
	localparam int T_EXT_MIN_NS = 1_000_000;
	localparam int T_EXT_MAX_NS = 2_100_000;
	localparam int T_DIS_NS = 300_000;
	localparam int T_GAP_NS = 1_000;
	localparam int T_EXIT_NS = 1_000;
	localparam int T_HALF_NS = 100;
	// Least waits round up, the window's upper edge rounds down
	localparam int BULK_CYC = (T_BULK_NS + CLK_NS - 1) / CLK_NS;
	localparam int ROW_CYC = (T_ROW_NS + CLK_NS - 1) / CLK_NS;
	localparam int PINT_PM_CYC = (T_PINT_PM_NS + CLK_NS - 1) / CLK_NS;
	localparam int PINT_CFG_CYC = (T_PINT_CFG_NS + CLK_NS - 1) / CLK_NS;
	localparam int EXT_MIN_CYC = (T_EXT_MIN_NS + CLK_NS - 1) / CLK_NS;
	localparam int EXT_MAX_CYC = T_EXT_MAX_NS / CLK_NS;
	localparam int DIS_CYC = (T_DIS_NS + CLK_NS - 1) / CLK_NS;
	localparam int GAP_CYC = (T_GAP_NS + CLK_NS - 1) / CLK_NS;
	localparam int EXIT_CYC = (T_EXIT_NS + CLK_NS - 1) / CLK_NS;
	localparam int HALF_CYC = (T_HALF_NS + CLK_NS - 1) / CLK_NS;
	// Widths
	localparam int WAIT_W = 20;
	localparam int CMD_W = 8;
	localparam int WORD_W = 14;
	localparam int SUM_W = 16;
	localparam int NIB_W = 4;
	// Values after reset
	localparam logic [SUM_W-1:0] SUM_RST = 16'h0000;
	localparam logic [WAIT_W-1:0] HCNT_SAT = 20'hfffff;
	localparam logic [CMD_W-1:0] CMD_RST = 8'h00;
	typedef logic [WAIT_W-1:0] nptc_wait_t;
	// Link operations that the sequencer knows how to pace
	typedef enum logic [2:0] {
		OP_PLAIN, OP_BULK, OP_ROW, OP_PINT_PM, OP_PINT_CFG, OP_EXT, OP_EXT_END, OP_EXIT
	} nptc_op_t;
	// Checksum engine operations
	typedef enum logic [2:0] {
		SUM_CLEAR, SUM_MEM, SUM_CFG, SUM_UID, SUM_FINISH
	} nptc_sum_op_t;
	// Sequencer states
	typedef enum logic [1:0] {
		ST_IDLE, ST_SHIFT, ST_HOLD, ST_WAIT
	} nptc_state_t;
endpackage : nptc_pkg

// file: logic/nptc_host.sv
`timescale 1ns/1ps
// Operation
// - Sum every program word from address zero
// - Keep sum 16 bits, drop carries
// - Add configuration words ANDed with mask
// - Upper two bits of words are zero
// - Checksum nibbles into user IDs, MSN first
// - Protected value from user ID low nibbles
// - Protected checksum: ID value plus configuration
// - Compare device ID, warn on mismatch
// - Warn when configuration words are absent
// - Saved image keeps configuration and IDs
// - Wait bulk erase time after bulk erase
// - Wait row erase time after row erase
// - Wait internal write time before next command
// - End external write inside its window
// - Wait after end of external write
// - Release data line before next clock
// - Wait exit delay when leaving mode
module nptc_host #(
	parameter int BULK_CYC = nptc_pkg::BULK_CYC,
	parameter int ROW_CYC = nptc_pkg::ROW_CYC,
	parameter int PINT_PM_CYC = nptc_pkg::PINT_PM_CYC,
	parameter int PINT_CFG_CYC = nptc_pkg::PINT_CFG_CYC,
	parameter int EXT_MIN_CYC = nptc_pkg::EXT_MIN_CYC,
	parameter int EXT_MAX_CYC = nptc_pkg::EXT_MAX_CYC,
	parameter int DIS_CYC = nptc_pkg::DIS_CYC
) (
	input wire logic clock,
	input wire logic rst_b,
	input wire logic cmd_valid,
	input wire nptc_pkg::nptc_op_t cmd_op,
	input wire logic [7:0] cmd_code,
	input wire logic [7:0] cmd_end_code,
	output logic cmd_ready,
	output logic mode_exited,
	input wire logic sum_valid,
	input wire nptc_pkg::nptc_sum_op_t sum_op,
	input wire logic [13:0] sum_word,
	input wire logic [13:0] sum_mask,
	input wire logic sum_protected,
	input wire logic [1:0] uid_sel,
	output logic [15:0] checksum,
	output logic [3:0] uid_nibble,
	output logic cfg_absent,
	input wire logic id_check,
	input wire logic [13:0] id_expected,
	input wire logic [13:0] id_read,
	output logic id_mismatch,
	output logic prog_serial_clock,
	input wire logic prog_serial_data_in,
	output logic prog_serial_data_out,
	output logic prog_serial_data_oe_b,
	output logic [7:0] line_echo
);
	// Whole state of the sequencer and checksum engine
	typedef struct packed {
		nptc_pkg::nptc_state_t st; // Sequencer state
		nptc_pkg::nptc_op_t op; // Operation being paced
		nptc_pkg::nptc_wait_t wcnt; // Wait down-counter
		logic [2:0] div; // Half-period divider
		logic [2:0] bits; // Bits sent so far
		logic [7:0] sh; // Outgoing command byte
		logic [7:0] end_code; // Held end-of-write code
		logic clk; // Link clock we drive
		logic dat; // Data we drive
		logic oe_b; // Low while we drive data
		logic ready; // Accepting a command
		logic exited; // Exit delay done pulse
		logic s0; // Data pin synchroniser, first stage
		logic s1; // Data pin synchroniser, second stage
		logic [7:0] rx; // Line level seen at each fall
		logic [15:0] msum; // Program memory sum
		logic [15:0] csum; // Masked configuration sum
		logic [15:0] uid; // Value rebuilt from user IDs
		logic [15:0] chk; // Finished checksum
		logic cfg_seen; // Any configuration word added
		logic cfg_abs; // Warning: no configuration words
		logic id_mis; // Warning: device ID differs
		logic [3:0] nib; // Selected checksum nibble
		nptc_pkg::nptc_wait_t hcnt; // Cycles since data release or exit request
		nptc_pkg::nptc_op_t hop; // Operation of that release or exit request
	} nptc_regs_t;

	nptc_regs_t s;
	nptc_regs_t next_s;

	// Cycles to hold off after an operation; counter loads N-1
	function automatic nptc_pkg::nptc_wait_t wait_of(input nptc_pkg::nptc_op_t op);
		int n;
		n = nptc_pkg::GAP_CYC;
		unique case (op)
			nptc_pkg::OP_PLAIN: n = nptc_pkg::GAP_CYC;
			nptc_pkg::OP_BULK: n = BULK_CYC;
			nptc_pkg::OP_ROW: n = ROW_CYC;
			nptc_pkg::OP_PINT_PM: n = PINT_PM_CYC;
			nptc_pkg::OP_PINT_CFG: n = PINT_CFG_CYC;
			nptc_pkg::OP_EXT: n = EXT_MIN_CYC;
			nptc_pkg::OP_EXT_END: n = DIS_CYC;
			nptc_pkg::OP_EXIT: n = nptc_pkg::EXIT_CYC;
		endcase
		return nptc_pkg::nptc_wait_t'(n - 1);
	endfunction : wait_of

	// Nibble that goes to user ID word idx; word 0 takes the top nibble
	function automatic logic [3:0] nib_of(input logic [15:0] v, input logic [1:0] idx);
		return v[(3 - idx) * 4 +: 4];
	endfunction : nib_of

	// Next-state logic for link sequencer and checksum engine
	always_comb begin
		next_s = s;
		next_s.exited = 1'b0;
		// Pin passes two flops before anything reads it
		next_s.s0 = prog_serial_data_in;
		next_s.s1 = s.s0;
		// Saturating distance from the last data release or exit request
		if (s.hcnt != nptc_pkg::HCNT_SAT) begin
			next_s.hcnt = s.hcnt + 20'h00001;
		end
		unique case (s.st)
			nptc_pkg::ST_IDLE: begin
				if (cmd_valid) begin
					next_s.ready = 1'b0;
					next_s.op = cmd_op;
					next_s.sh = cmd_code;
					next_s.end_code = cmd_end_code;
					if (cmd_op == nptc_pkg::OP_EXIT) begin
						// Exit sends nothing, only keeps lines quiet
						next_s.st = nptc_pkg::ST_WAIT;
						next_s.wcnt = wait_of(cmd_op);
						next_s.hcnt = '0;
						next_s.hop = cmd_op;
					end else begin
						// Start shifting: first bit out, clock low
						next_s.st = nptc_pkg::ST_SHIFT;
						next_s.oe_b = 1'b0;
						next_s.dat = cmd_code[7];
						next_s.div = 3'(nptc_pkg::HALF_CYC - 1);
						next_s.bits = 3'h0;
					end
				end
			end
			nptc_pkg::ST_SHIFT: begin
				if (s.div != 3'h0) begin
					next_s.div = s.div - 3'h1;
				end else begin
					next_s.div = 3'(nptc_pkg::HALF_CYC - 1);
					if (!s.clk) begin
						// Rise: data changes here, a half period before the fall
						next_s.clk = 1'b1;
						next_s.dat = s.sh[7];
					end else begin
						// Fall: device takes the bit
						next_s.clk = 1'b0;
						next_s.sh = {s.sh[6:0], 1'b0};
						next_s.rx = {s.rx[6:0], s.s1};
						next_s.bits = s.bits + 3'h1;
						if (s.bits == 3'h7) begin
							next_s.st = nptc_pkg::ST_HOLD;
						end
					end
				end
			end
			nptc_pkg::ST_HOLD: begin
				// Hold the last bit a half period past the fall, then let go
				if (s.div != 3'h0) begin
					next_s.div = s.div - 3'h1;
				end else begin
					next_s.oe_b = 1'b1;
					next_s.st = nptc_pkg::ST_WAIT;
					next_s.wcnt = wait_of(s.op);
					next_s.hcnt = '0;
					next_s.hop = s.op;
				end
			end
			nptc_pkg::ST_WAIT: begin
				if (s.wcnt != '0) begin
					next_s.wcnt = s.wcnt - 20'h00001;
				end else if (s.op == nptc_pkg::OP_EXT) begin
					// Window open: close the write at its earliest moment
					next_s.op = nptc_pkg::OP_EXT_END;
					next_s.sh = s.end_code;
					next_s.st = nptc_pkg::ST_SHIFT;
					next_s.oe_b = 1'b0;
					next_s.dat = s.end_code[7];
					next_s.div = 3'(nptc_pkg::HALF_CYC - 1);
					next_s.bits = 3'h0;
				end else begin
					next_s.st = nptc_pkg::ST_IDLE;
					next_s.ready = 1'b1;
					next_s.exited = (s.op == nptc_pkg::OP_EXIT);
				end
			end
		endcase
		// Checksum engine, one word per strobe
		if (sum_valid) begin
			unique case (sum_op)
				nptc_pkg::SUM_CLEAR: begin
					next_s.msum = nptc_pkg::SUM_RST;
					next_s.csum = nptc_pkg::SUM_RST;
					next_s.uid = nptc_pkg::SUM_RST;
					next_s.cfg_seen = 1'b0;
				end
				nptc_pkg::SUM_MEM: begin
					// Carries beyond bit 15 fall away
					next_s.msum = s.msum + {2'b00, sum_word};
				end
				nptc_pkg::SUM_CFG: begin
					next_s.csum = s.csum + {2'b00, sum_word & sum_mask};
					next_s.cfg_seen = 1'b1;
				end
				nptc_pkg::SUM_UID: begin
					// First user ID shifts furthest, ending as the top nibble
					next_s.uid = {s.uid[11:0], sum_word[3:0]};
				end
				nptc_pkg::SUM_FINISH: begin
					next_s.chk = sum_protected ? s.uid + s.csum : s.msum + s.csum;
					next_s.cfg_abs = !s.cfg_seen;
				end
				default: begin
					next_s.chk = s.chk;
				end
			endcase
		end
		next_s.nib = nib_of(s.chk, uid_sel);
		// Result stands until the next comparison
		if (id_check) begin
			next_s.id_mis = (id_expected != id_read);
		end
	end

	// One register bank for the whole block
	always_ff @(posedge clock) begin
		if (!rst_b) begin
			next_s_reset : begin
				s <= '0;
				s.st <= nptc_pkg::ST_IDLE;
				s.op <= nptc_pkg::OP_PLAIN;
				s.hop <= nptc_pkg::OP_PLAIN;
				s.oe_b <= 1'b1;
				s.ready <= 1'b1;
				s.sh <= nptc_pkg::CMD_RST;
				s.hcnt <= nptc_pkg::HCNT_SAT;
			end
		end else begin
			s <= next_s;
		end
	end

	// Outputs straight from the register bank
	assign cmd_ready = s.ready;
	assign mode_exited = s.exited;
	assign checksum = s.chk;
	assign uid_nibble = s.nib;
	assign cfg_absent = s.cfg_abs;
	assign id_mismatch = s.id_mis;
	assign prog_serial_clock = s.clk;
	assign prog_serial_data_out = s.dat;
	assign prog_serial_data_oe_b = s.oe_b;
	assign line_echo = s.rx;

	default clocking cb @(posedge clock); endclocking
	default disable iff (!rst_b);

	// Timing checks measure from data release to the next rising clock; the exit check runs from the exit request to the exit pulse
	property p_bulk;
		$rose(s.clk) && s.hop == nptc_pkg::OP_BULK |-> s.hcnt >= BULK_CYC;
	endproperty
	a_bulk: assert property (p_bulk) else $error("bulk erase wait too short");
	property p_row;
		$rose(s.clk) && s.hop == nptc_pkg::OP_ROW |-> s.hcnt >= ROW_CYC;
	endproperty
	a_row: assert property (p_row) else $error("row erase wait too short");
	property p_pint;
		$rose(s.clk) && s.hop == nptc_pkg::OP_PINT_CFG |-> s.hcnt >= PINT_CFG_CYC;
	endproperty
	a_pint: assert property (p_pint) else $error("internal write wait too short");
	property p_ext;
		$rose(s.clk) && s.hop == nptc_pkg::OP_EXT |->
			s.hcnt >= EXT_MIN_CYC && s.hcnt <= EXT_MAX_CYC;
	endproperty
	a_ext: assert property (p_ext) else $error("end command outside window");
	property p_dis;
		$rose(s.clk) && s.hop == nptc_pkg::OP_EXT_END |-> s.hcnt >= DIS_CYC;
	endproperty
	a_dis: assert property (p_dis) else $error("post end wait too short");
	property p_gap;
		$rose(s.clk) |-> s.hcnt >= nptc_pkg::GAP_CYC && !s.oe_b;
	endproperty
	a_gap: assert property (p_gap) else $error("inter command gap too short");
	property p_exit;
		s.exited |-> s.hop == nptc_pkg::OP_EXIT && s.hcnt >= nptc_pkg::EXIT_CYC;
	endproperty
	a_exit: assert property (p_exit) else $error("exit delay too short");
	property p_mem;
		sum_valid && sum_op == nptc_pkg::SUM_MEM |=>
			s.msum == 16'($past(s.msum) + {2'b00, $past(sum_word)});
	endproperty
	a_mem: assert property (p_mem) else $error("memory sum wrong");
	property p_cfg;
		sum_valid && sum_op == nptc_pkg::SUM_CFG |=>
			s.csum - $past(s.csum) == {2'b00, $past(sum_word) & $past(sum_mask)};
	endproperty
	a_cfg: assert property (p_cfg) else $error("configuration sum not masked");
	property p_uid;
		sum_valid && sum_op == nptc_pkg::SUM_UID ##1
			sum_valid && sum_op == nptc_pkg::SUM_UID |=> s.uid[7:0] ==
			{$past(sum_word[3:0], 2), $past(sum_word[3:0])};
	endproperty
	a_uid: assert property (p_uid) else $error("user ID nibble order wrong");
	property p_nib;
		##1 s.nib == nib_of($past(s.chk), $past(uid_sel));
	endproperty
	a_nib: assert property (p_nib) else $error("user ID nibble wrong");
	property p_id;
		id_check |=> s.id_mis == ($past(id_expected) != $past(id_read));
	endproperty
	a_id: assert property (p_id) else $error("device ID warning wrong");

	c_bulk: cover property ($rose(s.clk) && s.hop == nptc_pkg::OP_BULK);
	c_ext: cover property ($rose(s.clk) && s.hop == nptc_pkg::OP_EXT);
	c_exit: cover property (s.exited);
	c_prot: cover property (sum_valid && sum_op == nptc_pkg::SUM_FINISH && sum_protected);
endmodule : nptc_host

// file: test/nptc_dev_model.sv
`timescale 1ns/1ps
// Device on the far side of the link: takes command bytes on the falling clock
module nptc_dev_model #(
	parameter logic [7:0] BULK_CODE = 8'h18
) (
	input wire logic prog_serial_clock,
	input wire logic line,
	input wire logic oe_b,
	output int byte_count,
	output logic [7:0] last_byte,
	output realtime t_done,
	output realtime t_start,
	output int gap_viol
);
	logic [7:0] shreg; // Bits of the byte in flight
	int bits;
	realtime t_rel; // When the host last let go of the line
	logic brownout_trip_select;
	logic code_protect_bit; // Low means protected
	logic [13:0] mem_word;
	logic [13:0] cfg_word;
	logic [13:0] read_word;
	initial begin
		byte_count = 0;
		bits = 0;
		gap_viol = 0;
		t_rel = -1.0e6;
		brownout_trip_select = 1'b0;
		code_protect_bit = 1'b0;
		mem_word = 14'h00aa;
		cfg_word = 14'h3fff; // Externally timed writes never touch it
	end
	// Protected memory reads back as zero
	assign read_word = code_protect_bit ? mem_word : 14'h0000;
	// Release only counts once traffic has started
	always @(posedge oe_b) if (byte_count > 0) t_rel = $realtime;
	// A new byte must find the line released long enough
	always @(posedge prog_serial_clock) if (bits == 0) begin
		t_start = $realtime;
		if (t_start - t_rel < 1000.0) gap_viol++;
	end
	// Sample only while the host drives, so reset glitches are ignored
	always @(negedge prog_serial_clock) if (oe_b === 1'b0) begin
		shreg = {shreg[6:0], line};
		bits++;
		if (bits == 8) begin
			bits = 0;
			last_byte = shreg;
			byte_count++;
			t_done = $realtime;
			if (shreg == BULK_CODE) begin
				brownout_trip_select = 1'b1;
				code_protect_bit = 1'b1;
			end
		end
	end
endmodule : nptc_dev_model

// file: test/tb.sv
`timescale 1ns/1ps
// Self-checking bench for the programming sequencer
module tb;
	logic clock, rst_b, cmd_valid, sum_valid, sum_protected, id_check;
	nptc_pkg::nptc_op_t cmd_op;
	nptc_pkg::nptc_sum_op_t sum_op;
	logic [7:0] cmd_code, cmd_end_code, line_echo, last_byte;
	logic [13:0] sum_word, sum_mask, id_expected, id_read;
	logic [1:0] uid_sel;
	logic cmd_ready, mode_exited, cfg_absent, id_mismatch, psc, pdo, oe_b, last_drv;
	logic [15:0] checksum, e, p;
	logic [3:0] uid_nibble;
	wire logic line;
	int err_count, checked, cyc, byte_count, gap_viol, n, b;
	realtime t_done, t_start, t1;
	localparam logic [13:0] CW[5] = '{14'h3fff, 14'h3fff, 14'h3fff, 14'h3fff, 14'h3ffe};
	localparam logic [13:0] CM[5] = '{14'h2f77, 14'h3ee7, 14'h3f7f, 14'h2f9f, 14'h0001};
	// Released line shows the inverse of what was last driven: no pull
	assign line = !oe_b ? pdo : ~last_drv;
	// Single driver for the remembered level, cleared by reset
	always @(posedge clock) begin
		if (!rst_b) last_drv <= 1'b0;
		else if (!oe_b) last_drv <= pdo;
	end
	// Window top and post-end wait keep their real counts, so both are exercised as built
	nptc_host #(.BULK_CYC(200), .ROW_CYC(100), .PINT_PM_CYC(100), .PINT_CFG_CYC(150),
		.EXT_MIN_CYC(60)) nptc_host_inst (
		.clock(clock), .rst_b(rst_b), .cmd_valid(cmd_valid), .cmd_op(cmd_op),
		.cmd_code(cmd_code), .cmd_end_code(cmd_end_code), .cmd_ready(cmd_ready),
		.mode_exited(mode_exited), .sum_valid(sum_valid), .sum_op(sum_op),
		.sum_word(sum_word), .sum_mask(sum_mask), .sum_protected(sum_protected),
		.uid_sel(uid_sel), .checksum(checksum), .uid_nibble(uid_nibble),
		.cfg_absent(cfg_absent), .id_check(id_check), .id_expected(id_expected),
		.id_read(id_read), .id_mismatch(id_mismatch), .prog_serial_clock(psc),
		.prog_serial_data_in(line), .prog_serial_data_out(pdo),
		.prog_serial_data_oe_b(oe_b), .line_echo(line_echo));
	nptc_dev_model nptc_dev_model_inst (.prog_serial_clock(psc), .line(line), .oe_b(oe_b),
		.byte_count(byte_count), .last_byte(last_byte), .t_done(t_done),
		.t_start(t_start), .gap_viol(gap_viol));
	initial begin
		clock = 1'b0;
		forever #10 clock = ~clock;
	end
	// Compare and count
	task check(input logic [15:0] got, input logic [15:0] exp);
		checked++;
		if (got !== exp) begin
			err_count++;
			$display("ERROR at %0t: saw %h, expected %h", $time, got, exp);
		end
	endtask : check
	task close_out;
		$display("Checks %0d, mismatches %0d", checked, err_count);
		if (err_count == 0 && checked > 0) $display("Test passed");
		else $display("Test failed");
		$finish;
	endtask : close_out
	// Hang guard, well above the whole sequence
	always @(posedge clock) begin
		cyc++;
		if (cyc == 30000) begin
			err_count++;
			close_out();
		end
	end
	// Request held until taken, dropped on the next falling edge
	task issue(input nptc_pkg::nptc_op_t op, input logic [7:0] c, input logic [7:0] ec);
		@(negedge clock);
		cmd_op = op;
		cmd_code = c;
		cmd_end_code = ec;
		cmd_valid = 1'b1;
		// Ready seen high at a fall means the next rise takes the request
		while (cmd_ready !== 1'b1) @(negedge clock);
		@(negedge clock);
		cmd_valid = 1'b0;
	endtask : issue
	// Counts edges until the sequencer is free again
	task wait_ready;
		while (cmd_ready !== 1'b1 && n < 20000) begin
			@(posedge clock);
			#1 n++;
		end
	endtask : wait_ready
	// One command; with poke a second request is pressed while busy
	task t_cmd(input nptc_pkg::nptc_op_t op, input logic [7:0] c, input int w, input bit poke);
		b = byte_count;
		n = 0;
		issue(op, c, 8'h00);
		if (poke) begin
			// Let one fall pass so the strobe is not dropped and raised at once
			@(negedge clock);
			cmd_valid = 1'b1;
			cmd_code = ~c;
			repeat (19) @(negedge clock);
			cmd_valid = 1'b0;
			n = 20;
		end
		wait_ready();
		check(16'(last_byte), 16'(c));
		check(16'(byte_count), 16'(b + 1));
		check(16'(line_echo), 16'(c));
		check(16'(n >= 85 + w && n <= 90 + w), 16'h0001);
		$display("Command %s done after %0d cycles", op.name(), n);
	endtask : t_cmd
	// Externally timed write: end byte inside the window, then the post-end wait
	task t_ext;
		b = byte_count;
		n = 0;
		issue(nptc_pkg::OP_EXT, 8'hc3, 8'h3d);
		while (byte_count == b && n < 500) begin
			@(posedge clock);
			#1 n++;
		end
		t1 = t_done;
		wait_ready();
		check(16'(last_byte), 16'h003d);
		check(16'(t_start - t1 >= 1200.0 && t_start - t1 <= 2400.0), 16'h0001);
		check(16'(line_echo), 16'h003d);
		check(16'(n >= 85 + 60 + 85 + nptc_pkg::DIS_CYC), 16'h0001);
		check(16'(n <= 90 + 60 + 85 + nptc_pkg::DIS_CYC), 16'h0001);
		$display("External write done after %0d cycles", n);
	endtask : t_ext
	// Leaving the mode: quiet link, then one pulse
	task t_exit;
		b = byte_count;
		n = 0;
		issue(nptc_pkg::OP_EXIT, 8'h00, 8'h00);
		while (mode_exited !== 1'b1 && n < 500) begin
			@(posedge clock);
			#1 n++;
		end
		check(16'(n >= 49 && n <= 54), 16'h0001);
		check(16'(byte_count), 16'(b));
		check(16'(oe_b), 16'h0001);
		@(posedge clock);
		#1 check(16'(mode_exited), 16'h0000);
		$display("Exit done after %0d cycles", n);
	endtask : t_exit
	// One checksum word per cycle, strobe held between calls
	task sum(input nptc_pkg::nptc_sum_op_t op, input logic [13:0] w, input logic [13:0] m);
		sum_valid = 1'b1;
		sum_op = op;
		sum_word = w;
		sum_mask = m;
		@(negedge clock);
	endtask : sum
	task finish(input logic prot);
		sum_protected = prot;
		sum(nptc_pkg::SUM_FINISH, 14'h0000, 14'h0000);
		sum_valid = 1'b0;
		@(posedge clock);
		#1;
	endtask : finish
	// Unprotected, protected and missing-configuration sums
	task t_sums;
		e = 16'h0000;
		@(negedge clock);
		sum(nptc_pkg::SUM_CLEAR, 14'h0000, 14'h0000);
		for (int i = 0; i < 4; i++) begin
			sum(nptc_pkg::SUM_MEM, 14'h3fff - 14'(i), 14'h0000);
			e = e + {2'b00, 14'h3fff - 14'(i)};
		end
		e = e + {2'b00, CW[0] & CM[0]};
		sum(nptc_pkg::SUM_CFG, CW[0], CM[0]);
		finish(1'b0);
		check(checksum, e);
		check(16'(cfg_absent), 16'h0000);
		for (int i = 0; i < 4; i++) begin
			@(negedge clock);
			uid_sel = 2'(i);
			@(posedge clock);
			@(posedge clock);
			#1 check(16'(uid_nibble), 16'(e[15 - 4 * i -: 4]));
		end
		p = e;
		@(negedge clock);
		sum(nptc_pkg::SUM_CLEAR, 14'h0000, 14'h0000);
		for (int i = 0; i < 4; i++) sum(nptc_pkg::SUM_UID, {10'h2a5, e[15 - 4 * i -: 4]}, 14'h0000);
		for (int i = 0; i < 5; i++) begin
			sum(nptc_pkg::SUM_CFG, CW[i], CM[i]);
			p = p + {2'b00, CW[i] & CM[i]};
		end
		finish(1'b1);
		check(checksum, p);
		@(negedge clock);
		sum(nptc_pkg::SUM_CLEAR, 14'h0000, 14'h0000);
		sum(nptc_pkg::SUM_MEM, 14'h00aa, 14'h0000);
		finish(1'b0);
		check(16'(cfg_absent), 16'h0001);
		check(checksum, 16'h00aa);
		$display("Checksum tests done");
	endtask : t_sums
	// Identity compare, equal then different
	task t_id;
		for (int i = 0; i < 2; i++) begin
			@(negedge clock);
			id_expected = 14'h1234;
			id_read = 14'h1234 ^ 14'(i);
			id_check = 1'b1;
			@(negedge clock);
			id_check = 1'b0;
			check(16'(id_mismatch), 16'(i));
		end
		$display("Identity tests done");
	endtask : t_id
	initial begin
		{cmd_valid, sum_valid, sum_protected, id_check} = 4'h0;
		{cmd_code, cmd_end_code, uid_sel} = 18'h00000;
		{sum_word, sum_mask, id_expected, id_read} = 56'h0;
		cmd_op = nptc_pkg::OP_PLAIN;
		sum_op = nptc_pkg::SUM_CLEAR;
		err_count = 0;
		checked = 0;
		cyc = 0;
		rst_b = 1'b0;
		repeat (5) @(negedge clock);
		rst_b = 1'b1;
		t_cmd(nptc_pkg::OP_PLAIN, 8'ha5, 50, 1'b0);
		t_cmd(nptc_pkg::OP_BULK, 8'h18, 200, 1'b0);
		check(16'(nptc_dev_model_inst.brownout_trip_select), 16'h0001);
		t_cmd(nptc_pkg::OP_ROW, 8'hf0, 100, 1'b1);
		t_cmd(nptc_pkg::OP_PINT_PM, 8'h81, 100, 1'b0);
		t_cmd(nptc_pkg::OP_PINT_CFG, 8'h7e, 150, 1'b0);
		t_ext();
		// A command after the end byte puts the post-end wait under watch
		t_cmd(nptc_pkg::OP_PLAIN, 8'h5a, 50, 1'b0);
		t_exit();
		check(16'(gap_viol), 16'h0000);
		t_sums();
		t_id();
		close_out();
	end
endmodule : tb
